// >>> hw/ascii_serial_command_port.sv
// ascii command front end: apb registers, line buffer, decode, replies
// assumes an apb master on clk_sys and a peer at the same baud and parity
//
// Overview of operation
// R1: buffered command acts only after carriage return arrives
// R2: every transmitted message ends with carriage return then line feed
// R3: host keeps inter-character gaps within two seconds
// R4: gap over two seconds drops partial buffer; next char starts fresh
// R5: host sends one command per terminated string
// R6: echo setting returns each received character, or nothing
// R7: echo off on multidrop line except for testing
// R8: reply must begin within 25 ms of the carriage return
// R9: first two characters pick the command; value follows them
// R10: command letters match regardless of case
// R11: unknown command pair gets an invalid-command reply
// R12: unit address zero accepts every command without selection
// R13: units hold distinct addresses; host address alerts one unit
// R14: host attaches at most 32 units per bus
// R15: baud and parity configurable; peer uses same settings
// R16: batch completion requests a ticket with configured printer type
// R17: no printer attached means type 00, never 03
// R18: time kept in 24-hour form; date order set by format bit
// R19: select with decimal address selects matching unit, no reply
// R20: selection lasts until another select command
// R21: select without value makes selected unit reply its address
// R22: unselected nonzero unit ignores commands, no echo or reply
//
// Register access over APB and the address map were left to the implementer.
module ascii_serial_command_port #(
  parameter int GAP_CYC = cmd_port_pkg::GAP_CYC,
  parameter int RESP_CYC = cmd_port_pkg::RESP_CYC,
  parameter int SEC_CYC = cmd_port_pkg::SEC_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic batch_done,
  output logic print_req,
  output logic [3:0] print_type,
  output logic date_fmt_us
);
  localparam int W = cmd_port_pkg::CNT_W;

  logic [1:0] rst_sync_q;
  logic rst_n;
  cmd_port_pkg::cfg_t cfg_q;
  logic [15:0] baud_q;
  logic apb_req, apb_wr, hit;
  logic [31:0] rd_mux;
  logic rx_valid, rx_perr, tx_busy;
  logic [7:0] rx_byte;
  logic [7:0] buf_q [0:cmd_port_pkg::BUF_DEPTH-1];
  logic [4:0] len_q, base;
  logic [W-1:0] gap_cnt_q, resp_cnt_q, sec_cnt_q;
  logic gap_exp, accept, rx_ok, proc, is_id, known, hw_inv, hw_uid;
  logic [7:0] c0, c1;
  logic [3:0] code, cmd_q, argsel_q;
  logic [4:0] cmd_len_q;
  logic [9:0] id_val;
  logic sel_q, cmd_rdy_q, perr_q, ovf_q, late_q, resp_on_q;
  logic mreq_q, mend_q, run_end_q, echo_pend_q, tx_start_q;
  logic [7:0] mbyte_q, echo_byte_q, tx_byte_q, msg_char;
  cmd_port_pkg::msg_kind_t mkind_q, run_kind_q;
  cmd_port_pkg::msg_st_t st_q;
  logic [1:0] idx_q;
  logic free, send_msg, send_echo, msg_go, tx_rdy, sw_wr, last, stat_wr;
  logic [5:0] ss_q, mm_q;
  logic [4:0] hh_q;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // one wait state: pready rises in the second access cycle
  assign apb_req = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign sw_wr = apb_wr && paddr == cmd_port_pkg::A_TX;
  assign stat_wr = apb_wr && paddr == cmd_port_pkg::A_STAT;

  // read mux and address decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      cmd_port_pkg::A_CTRL: rd_mux[15:0] = cfg_q;
      cmd_port_pkg::A_BAUD: rd_mux[15:0] = baud_q;
      cmd_port_pkg::A_STAT: begin
        rd_mux[cmd_port_pkg::ST_RDY] = cmd_rdy_q;
        rd_mux[cmd_port_pkg::ST_SEL] = sel_q;
        rd_mux[cmd_port_pkg::ST_TXRDY] = tx_rdy;
        rd_mux[cmd_port_pkg::ST_PERR] = perr_q;
        rd_mux[cmd_port_pkg::ST_OVF] = ovf_q;
        rd_mux[cmd_port_pkg::ST_LATE] = late_q;
        rd_mux[cmd_port_pkg::ST_LEN +: 5] = len_q;
      end
      cmd_port_pkg::A_CMD: begin
        rd_mux[3:0] = cmd_q;
        rd_mux[cmd_port_pkg::CM_LEN +: 5] = cmd_len_q;
      end
      cmd_port_pkg::A_ARG: rd_mux[7:0] = buf_q[argsel_q];
      cmd_port_pkg::A_TX: rd_mux[cmd_port_pkg::ST_TXRDY] = tx_rdy;
      cmd_port_pkg::A_TIME: begin
        rd_mux[cmd_port_pkg::TM_SS +: 6] = ss_q;
        rd_mux[cmd_port_pkg::TM_MM +: 6] = mm_q;
        rd_mux[cmd_port_pkg::TM_HH +: 5] = hh_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // apb answer flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_req;
      pslverr <= apb_req && !hit;
      if (apb_req) begin
        prdata <= rd_mux;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= cmd_port_pkg::CFG_RST;
      baud_q <= cmd_port_pkg::BAUD_RST;
      argsel_q <= 4'h0;
    end else if (apb_wr) begin
      if (paddr == cmd_port_pkg::A_CTRL) cfg_q <= pwdata[15:0]; // [R15] [R7]
      if (paddr == cmd_port_pkg::A_BAUD) baud_q <= pwdata[15:0]; // [R15]
      if (paddr == cmd_port_pkg::A_ARG) argsel_q <= pwdata[3:0];
    end
  end

  serial_line u_line (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .divisor(baud_q),
    .parity_en(cfg_q.parity_en),
    .parity_odd(cfg_q.parity_odd),
    .rxd(rxd),
    .tx_start(tx_start_q),
    .tx_byte(tx_byte_q),
    .txd(txd),
    .tx_busy(tx_busy),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_perr(rx_perr)
  );

  // inter-character gap timer, saturates once expired
  assign gap_exp = gap_cnt_q >= W'(GAP_CYC);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_q <= '0;
    end else if (rx_valid) begin
      gap_cnt_q <= '0;
    end else if (!gap_exp) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  assign accept = cfg_q.unit_addr == 8'h00 || sel_q; // [R12] [R22]
  assign rx_ok = rx_valid && !rx_perr;
  assign proc = rx_ok && rx_byte == cmd_port_pkg::CH_CR; // [R1]
  assign base = gap_exp ? 5'h00 : len_q; // [R4]

  // line buffer; characters past the end are dropped and flagged
  always_ff @(posedge clk_sys) begin
    if (rx_ok && !proc && base < cmd_port_pkg::BUF_DEPTH) begin
      buf_q[base[3:0]] <= rx_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 5'h00;
    end else if (rx_ok) begin
      if (proc) len_q <= 5'h00;
      else if (base < cmd_port_pkg::BUF_DEPTH) len_q <= 5'(base + 5'h01);
      else len_q <= base;
    end else if (gap_exp) begin
      len_q <= 5'h00; // [R4]
    end
  end

  // fold lower case onto upper case before matching
  function automatic logic [7:0] upcase(input logic [7:0] ch);
    if (ch >= cmd_port_pkg::CH_LA && ch <= cmd_port_pkg::CH_LZ) begin
      return 8'(ch - cmd_port_pkg::CASE_OFS);
    end
    return ch;
  endfunction

  function automatic logic [3:0] decode(input logic [15:0] pair);
    case (pair)
      cmd_port_pkg::K_BV: return cmd_port_pkg::C_BV;
      cmd_port_pkg::K_BS: return cmd_port_pkg::C_BS;
      cmd_port_pkg::K_BH: return cmd_port_pkg::C_BH;
      cmd_port_pkg::K_BR: return cmd_port_pkg::C_BR;
      cmd_port_pkg::K_BC: return cmd_port_pkg::C_BC;
      cmd_port_pkg::K_TQ: return cmd_port_pkg::C_TQ;
      cmd_port_pkg::K_RQ: return cmd_port_pkg::C_RQ;
      cmd_port_pkg::K_BQ: return cmd_port_pkg::C_BQ;
      default: return cmd_port_pkg::C_NONE;
    endcase
  endfunction

  assign c0 = upcase(buf_q[0]); // [R10]
  assign c1 = upcase(buf_q[1]); // [R10]
  assign code = decode({c0, c1}); // [R9]
  assign is_id = len_q >= 5'h02 && {c0, c1} == cmd_port_pkg::K_ID;
  assign known = len_q >= 5'h02 && code != cmd_port_pkg::C_NONE;
  assign hw_inv = proc && accept && !is_id && len_q != 5'h00 && !known; // [R11]
  assign hw_uid = proc && accept && is_id && len_q == 5'h02; // [R21]

  // decimal value after the pair; junk or overflow never matches
  always_comb begin
    id_val = 10'h000;
    for (int i = 2; i < cmd_port_pkg::BUF_DEPTH; i++) begin
      if (i < len_q) begin
        if (buf_q[i] < cmd_port_pkg::CH_0 || buf_q[i] > cmd_port_pkg::CH_9 ||
            id_val > 10'h019) begin
          id_val = 10'h3FF;
        end else begin
          id_val = 10'(id_val * 10'h00A + 10'(buf_q[i] - cmd_port_pkg::CH_0)); // [R9]
        end
      end
    end
  end

  // selection and command hand-off to software; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      cmd_rdy_q <= 1'b0;
      cmd_q <= cmd_port_pkg::C_NONE;
      cmd_len_q <= 5'h00;
    end else begin
      if (proc && is_id && len_q > 5'h02) begin
        sel_q <= id_val == {2'b00, cfg_q.unit_addr}; // [R19] [R20] [R13]
      end
      if (proc && accept && !is_id && known) begin
        cmd_q <= code; // [R9] [R22]
        cmd_len_q <= len_q;
        cmd_rdy_q <= 1'b1;
      end else if (stat_wr && pwdata[cmd_port_pkg::ST_RDY]) begin
        cmd_rdy_q <= 1'b0;
      end
    end
  end

  // sticky faults, write one to clear, new event wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      perr_q <= 1'b0;
      ovf_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      if (rx_valid && rx_perr) perr_q <= 1'b1;
      else if (stat_wr && pwdata[cmd_port_pkg::ST_PERR]) perr_q <= 1'b0;
      if (rx_ok && !proc && base >= cmd_port_pkg::BUF_DEPTH) ovf_q <= 1'b1;
      else if (stat_wr && pwdata[cmd_port_pkg::ST_OVF]) ovf_q <= 1'b0;
      if (resp_on_q && resp_cnt_q == W'(RESP_CYC - 1)) late_q <= 1'b1;
      else if (stat_wr && pwdata[cmd_port_pkg::ST_LATE]) late_q <= 1'b0;
    end
  end

  // reply deadline watch from carriage return to first reply char
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_on_q <= 1'b0;
      resp_cnt_q <= '0;
    end else if (proc && accept && (known || hw_inv || hw_uid)) begin
      resp_on_q <= 1'b1; // [R8]
      resp_cnt_q <= '0;
    end else if (msg_go || resp_cnt_q == W'(RESP_CYC - 1)) begin
      resp_on_q <= 1'b0;
    end else if (resp_on_q) begin
      resp_cnt_q <= resp_cnt_q + 1'b1;
    end
  end

  // pending message; hardware replies start at once, software waits
  assign tx_rdy = !mreq_q && st_q == cmd_port_pkg::M_IDLE;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mreq_q <= 1'b0;
      mkind_q <= cmd_port_pkg::K_INV;
      mbyte_q <= 8'h00;
      mend_q <= 1'b0;
    end else if (hw_inv || hw_uid) begin
      mreq_q <= 1'b1; // [R8]
      mkind_q <= hw_uid ? cmd_port_pkg::K_UID : cmd_port_pkg::K_INV;
      mend_q <= 1'b1;
    end else if (sw_wr && tx_rdy) begin
      mreq_q <= 1'b1;
      mkind_q <= cmd_port_pkg::K_SW;
      mbyte_q <= pwdata[7:0];
      mend_q <= pwdata[cmd_port_pkg::TX_END];
    end else if (msg_go) begin
      mreq_q <= 1'b0;
    end
  end

  // echo only what this unit accepts; a collision hazard on a shared bus
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      echo_pend_q <= 1'b0;
      echo_byte_q <= 8'h00;
    end else if (rx_valid && cfg_q.echo && accept) begin
      echo_pend_q <= 1'b1; // [R6] [R22]
      echo_byte_q <= rx_byte;
    end else if (send_echo) begin
      echo_pend_q <= 1'b0;
    end
  end

  // a running message is never split by an echo
  assign free = !tx_busy && !tx_start_q;
  assign send_msg = free && st_q != cmd_port_pkg::M_IDLE;
  assign send_echo = free && st_q == cmd_port_pkg::M_IDLE && echo_pend_q;
  assign msg_go = st_q == cmd_port_pkg::M_IDLE && mreq_q && !send_echo;
  assign last = run_kind_q == cmd_port_pkg::K_SW || idx_q == 2'h2;

  // characters of the current message: body, carriage return, line feed
  always_comb begin
    msg_char = 8'h00;
    unique case (st_q)
      cmd_port_pkg::M_IDLE: msg_char = 8'h00;
      cmd_port_pkg::M_CR: msg_char = cmd_port_pkg::CH_CR;
      cmd_port_pkg::M_LF: msg_char = cmd_port_pkg::CH_LF;
      cmd_port_pkg::M_BODY: begin
        case (run_kind_q)
          cmd_port_pkg::K_INV: msg_char = cmd_port_pkg::INV_MSG[8 * (2 - idx_q) +: 8];
          cmd_port_pkg::K_UID: begin
            case (idx_q)
              2'h0: msg_char = 8'(cfg_q.unit_addr / 8'h64 + cmd_port_pkg::CH_0);
              2'h1: msg_char = 8'(cfg_q.unit_addr / 8'h0A % 8'h0A + cmd_port_pkg::CH_0);
              default: msg_char = 8'(cfg_q.unit_addr % 8'h0A + cmd_port_pkg::CH_0);
            endcase
          end
          cmd_port_pkg::K_SW: msg_char = mbyte_q;
          default: msg_char = 8'h00;
        endcase
      end
    endcase
  end

  // transmit sequencer: body, then carriage return and line feed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cmd_port_pkg::M_IDLE;
      idx_q <= 2'h0;
      run_kind_q <= cmd_port_pkg::K_INV;
      run_end_q <= 1'b0;
      tx_start_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else begin
      tx_start_q <= 1'b0;
      if (send_msg) begin
        tx_start_q <= 1'b1;
        tx_byte_q <= msg_char;
        unique case (st_q)
          cmd_port_pkg::M_BODY: begin
            idx_q <= idx_q + 2'h1;
            if (last) st_q <= run_end_q ? cmd_port_pkg::M_CR : cmd_port_pkg::M_IDLE; // [R2]
          end
          cmd_port_pkg::M_CR: st_q <= cmd_port_pkg::M_LF; // [R2]
          cmd_port_pkg::M_LF: st_q <= cmd_port_pkg::M_IDLE;
          cmd_port_pkg::M_IDLE: st_q <= cmd_port_pkg::M_IDLE;
        endcase
      end else if (send_echo) begin
        tx_start_q <= 1'b1; // [R6]
        tx_byte_q <= echo_byte_q;
      end else if (msg_go) begin
        st_q <= cmd_port_pkg::M_BODY;
        idx_q <= 2'h0;
        run_kind_q <= mkind_q;
        run_end_q <= mend_q;
      end
    end
  end

  // 24-hour time of day, set by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_q <= '0;
      ss_q <= 6'h00;
      mm_q <= 6'h00;
      hh_q <= 5'h00;
    end else if (apb_wr && paddr == cmd_port_pkg::A_TIME) begin
      sec_cnt_q <= '0;
      ss_q <= pwdata[cmd_port_pkg::TM_SS +: 6];
      mm_q <= pwdata[cmd_port_pkg::TM_MM +: 6];
      hh_q <= pwdata[cmd_port_pkg::TM_HH +: 5];
    end else if (sec_cnt_q == W'(SEC_CYC - 1)) begin
      sec_cnt_q <= '0;
      ss_q <= (ss_q == cmd_port_pkg::SEC_MAX) ? 6'h00 : ss_q + 6'h01;
      if (ss_q == cmd_port_pkg::SEC_MAX) begin
        mm_q <= (mm_q == cmd_port_pkg::SEC_MAX) ? 6'h00 : mm_q + 6'h01;
        if (mm_q == cmd_port_pkg::SEC_MAX) begin
          hh_q <= (hh_q == cmd_port_pkg::HR_MAX) ? 5'h00 : hh_q + 5'h01; // [R18]
        end
      end
    end else begin
      sec_cnt_q <= sec_cnt_q + 1'b1;
    end
  end

  // ticket request and date order toward the print formatter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      print_req <= 1'b0;
      print_type <= 4'h0;
      date_fmt_us <= 1'b0;
    end else begin
      print_req <= batch_done; // [R16]
      if (batch_done) print_type <= cfg_q.ptype; // [R16]
      date_fmt_us <= cfg_q.date_fmt; // [R18]
    end
  end
endmodule

// >>> hw/cmd_port_pkg.sv
// shared constants, types and register map of the serial command port
// assumes a 25 MHz system clock and an apb master with 32-bit data
package cmd_port_pkg;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int GAP_MS = 2000;
  localparam int RESP_MS = 25;
  localparam int SEC_MS = 1000;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int RESP_CYC = CLK_HZ / 1000 * RESP_MS;
  localparam int SEC_CYC = CLK_HZ / 1000 * SEC_MS;
  localparam int CNT_W = 26;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0C;
  localparam logic [7:0] A_ARG = 8'h10;
  localparam logic [7:0] A_TX = 8'h14;
  localparam logic [7:0] A_TIME = 8'h18;
  // status and field positions
  localparam int ST_RDY = 0;
  localparam int ST_SEL = 1;
  localparam int ST_TXRDY = 2;
  localparam int ST_PERR = 3;
  localparam int ST_OVF = 4;
  localparam int ST_LATE = 5;
  localparam int ST_LEN = 8;
  localparam int CM_LEN = 8;
  localparam int TX_END = 8;
  localparam int TM_SS = 0;
  localparam int TM_MM = 8;
  localparam int TM_HH = 16;
  // reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0A2C;
  // line framing, bit times per frame with and without parity
  localparam logic [3:0] FRAME_P = 4'hB;
  localparam logic [3:0] FRAME_N = 4'hA;
  // buffer and characters
  localparam int BUF_DEPTH = 16;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [23:0] INV_MSG = 24'h494E56;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [4:0] HR_MAX = 5'h17;
  // command character pairs
  localparam logic [15:0] K_ID = 16'h4944;
  localparam logic [15:0] K_BV = 16'h4256;
  localparam logic [15:0] K_BS = 16'h4253;
  localparam logic [15:0] K_BH = 16'h4248;
  localparam logic [15:0] K_BR = 16'h4252;
  localparam logic [15:0] K_BC = 16'h4243;
  localparam logic [15:0] K_TQ = 16'h543F;
  localparam logic [15:0] K_RQ = 16'h523F;
  localparam logic [15:0] K_BQ = 16'h423F;
  // command codes shown to software
  localparam logic [3:0] C_NONE = 4'h0;
  localparam logic [3:0] C_BV = 4'h1;
  localparam logic [3:0] C_BS = 4'h2;
  localparam logic [3:0] C_BH = 4'h3;
  localparam logic [3:0] C_BR = 4'h4;
  localparam logic [3:0] C_BC = 4'h5;
  localparam logic [3:0] C_TQ = 4'h6;
  localparam logic [3:0] C_RQ = 4'h7;
  localparam logic [3:0] C_BQ = 4'h8;

  typedef struct packed {
    logic [3:0] ptype;
    logic [7:0] unit_addr;
    logic parity_odd;
    logic parity_en;
    logic date_fmt;
    logic echo;
  } cfg_t;

  typedef enum logic [1:0] {M_IDLE, M_BODY, M_CR, M_LF} msg_st_t;
  typedef enum logic [1:0] {K_INV, K_UID, K_SW} msg_kind_t;
endpackage

// >>> hw/serial_line.sv
// 8-bit async transmitter and receiver, optional parity, one stop bit
// assumes rxd already synchronous to clk_sys and divisor above one
module serial_line (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] divisor,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic rxd,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic txd,
  output logic tx_busy,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_perr
);
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_div_q;
  logic tx_tick;
  logic tx_par;
  logic rx_on_q;
  logic [3:0] rx_idx_q;
  logic [15:0] rx_div_q;
  logic [7:0] rx_sh_q;
  logic rx_pbit_q;
  logic rx_tick;
  logic [3:0] rx_last;

  assign tx_par = ^tx_byte ^ parity_odd;
  assign tx_tick = tx_div_q == 16'(divisor - 16'h0001);
  assign tx_busy = tx_left_q != 4'h0;

  // shift out start, data lsb first, parity, stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_div_q <= 16'h0000;
      txd <= 1'b1;
    end else if (tx_start) begin
      txd <= 1'b0;
      tx_div_q <= 16'h0000;
      if (parity_en) begin
        tx_sh_q <= {1'b1, tx_par, tx_byte, 1'b0};
        tx_left_q <= cmd_port_pkg::FRAME_P;
      end else begin
        tx_sh_q <= {2'b11, tx_byte, 1'b0};
        tx_left_q <= cmd_port_pkg::FRAME_N;
      end
    end else if (tx_busy) begin
      if (tx_tick) begin
        tx_div_q <= 16'h0000;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        txd <= tx_sh_q[1]; // ones fill in, so the line idles high
        tx_left_q <= tx_left_q - 4'h1;
      end else begin
        tx_div_q <= tx_div_q + 16'h0001;
      end
    end
  end

  assign rx_tick = rx_div_q == 16'(divisor - 16'h0001);
  assign rx_last = parity_en ? 4'hA : 4'h9;

  // sample mid-bit; a start bit high at mid-bit is a glitch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_on_q <= 1'b0;
      rx_idx_q <= 4'h0;
      rx_div_q <= 16'h0000;
      rx_sh_q <= 8'h00;
      rx_pbit_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_perr <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_on_q) begin
        if (!rxd) begin
          rx_on_q <= 1'b1;
          rx_idx_q <= 4'h0;
          rx_div_q <= {1'b0, divisor[15:1]};
        end
      end else if (rx_tick) begin
        rx_div_q <= 16'h0000;
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0) begin
          if (rxd) begin
            rx_on_q <= 1'b0;
          end
        end else if (rx_idx_q <= 4'h8) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        end else if (rx_idx_q == rx_last) begin
          rx_on_q <= 1'b0;
          rx_valid <= 1'b1;
          rx_byte <= rx_sh_q;
          // framing and parity faults share one flag
          rx_perr <= !rxd || (parity_en && (rx_pbit_q ^ (^rx_sh_q) ^ parity_odd));
        end else begin
          rx_pbit_q <= rxd;
        end
      end else begin
        rx_div_q <= rx_div_q + 16'h0001;
      end
    end
  end
endmodule

// >>> dv/host_line.sv
// host computer on the far side of the serial line
// assumes 8 data bits, no parity, one stop bit, bit time BIT_CYC
module host_line #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  // one frame lsb first, line left idle high after it
  task automatic put(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask
  // receiver: sample mid-bit, so edges at bit borders never race
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      sh = {txd, sh[7:1]};
    end
    got.push_back(sh);
    repeat (BIT_CYC) @(posedge clk_sys);
  end
endmodule

// >>> dv/cmd_port_props.sv
// timing checks on the apb, print and format pins of the port
// assumes one clock domain; bound to the top module
module cmd_port_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic batch_done,
  input wire logic print_req,
  input wire logic [3:0] print_type,
  input wire logic date_fmt_us
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_one_wait: assert property (s_wait |=> pready) else $error("no ready after wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_bad_addr: assert property (pready && paddr > 8'h18 |-> pslverr) else $error("no error");
  a_good_addr: assert property (pready && paddr[1:0] == 2'h0 && paddr < 8'h1C |-> !pslverr)
    else $error("error on mapped");
  a_print_pulse: assert property (
    batch_done |=> print_req) else $error("no print request");
  a_print_cause: assert property (
    print_req |-> $past(batch_done)) else $error("stray print request");
  a_print_single: assert property (
    print_req && !batch_done |=> !print_req) else $error("print request held");
  a_date_write: assert property (
    $changed(date_fmt_us) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("format changed alone");
endmodule
bind ascii_serial_command_port cmd_port_props u_cmd_port_props (.*);

// >>> dv/ascii_serial_command_port_tb.sv
// self-checking bench of the ascii command port
// assumes short timing parameters and the host model on the line
module ascii_serial_command_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic batch_done = 1'b0, pready, pslverr, rxd, txd, print_req, date_fmt_us, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] print_type;
  int mismatches = 0, checked = 0;
  always #20 clk_sys = ~clk_sys;
  ascii_serial_command_port #(.GAP_CYC(2000), .RESP_CYC(500), .SEC_CYC(100))
  u_ascii_serial_command_port (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .batch_done(batch_done),
    .print_req(print_req), .print_type(print_type), .date_fmt_us(date_fmt_us));
  host_line #(.BIT_CYC(8)) u_host_line (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %0h vs %0h", $time, g, e);
    end
  endtask
  // one transfer; pready and read data taken at one rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  task automatic say(input string s);
    for (int i = 0; i < s.len(); i++) u_host_line.put(s[i]);
  endtask
  task automatic hear(input string s);
    int n;
    n = 0;
    while (u_host_line.got.size() < s.len() && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    chk(u_host_line.got.size(), s.len());
    for (int i = 0; i < s.len(); i++) chk(u_host_line.got[i], s[i]);
    u_host_line.got.delete();
  endtask
  task automatic t_reset;
    rd(8'h04, 32'hFFFF, 32'h0A2C);
    rd(8'h00, 32'hFFFF, 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk(err, 1'b1);
    $display("end t_reset");
  endtask
  task automatic t_cmd;
    apb(1'b1, 8'h04, 32'h8);
    say("b");
    rd(8'h08, 32'h1, 32'h0);
    say("s\015");
    rd(8'h08, 32'h1, 32'h1);
    rd(8'h0C, 32'h1F0F, 32'h0202);
    apb(1'b1, 8'h14, 32'h141);
    hear("A\015\012");
    apb(1'b1, 8'h08, 32'h39);
    say("zz\015");
    hear("INV\015\012");
    $display("end t_cmd");
  endtask
  task automatic t_echo;
    apb(1'b1, 8'h00, 32'h1);
    say("q");
    hear("q");
    apb(1'b1, 8'h00, 32'h0);
    repeat (2100) @(posedge clk_sys);
    say("BH\015");
    rd(8'h0C, 32'h1F0F, 32'h0203);
    apb(1'b1, 8'h08, 32'h39);
    $display("end t_echo");
  endtask
  task automatic t_sel;
    apb(1'b1, 8'h00, 32'h70);
    say("bs\015");
    say("id007\015");
    rd(8'h08, 32'h3, 32'h2);
    say("bs\015");
    rd(8'h08, 32'h3, 32'h3);
    chk(u_host_line.got.size(), 0);
    say("id\015");
    hear("007\015\012");
    $display("end t_sel");
  endtask
  task automatic t_batch;
    apb(1'b1, 8'h00, 32'h5002);
    @(posedge clk_sys);
    batch_done <= 1'b1;
    @(posedge clk_sys);
    batch_done <= 1'b0;
    @(negedge clk_sys);
    chk(print_req, 1'b1);
    chk(print_type, 4'h5);
    chk(date_fmt_us, 1'b1);
    $display("end t_batch");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, well past the few thousand cycles the tests take
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset;
    t_cmd;
    t_echo;
    t_sel;
    t_batch;
    print_verdict;
  end
endmodule
